// [core/supv_pkg.sv]
// Purpose: shared constants and types of the supervisor block
// Assumes: one internal cycle is a fixed number of oscillator periods
// Notes: all window and reset lengths are counted in internal cycles
package supv_pkg;
  localparam int WORD_W = 8;
  localparam int TICK_W = 5;
  localparam int CNT_W = 7;
  localparam int OSC_PER_TICK = 32;
  localparam int POR_TICKS = 16;
  localparam int CLOSED_TICKS = 16;
  localparam int OPEN_TICKS = 16;
  localparam int WDR_TICKS = 4;
  localparam int LONG_TICKS = 32;
  localparam int AUTO_PERIOD = 128;
  localparam int AUTO_ON = 2;
  // control word bit positions
  localparam int B_TRIG = 0;
  localparam int B_WDCTL = 1;
  localparam int B_TXEN = 2;
  localparam int B_NSTB = 3;
  localparam int B_AUTO = 4;
  localparam int B_HSON = 5;
  localparam int B_EWEN = 6;
  localparam int B_MASK = 7;
  // diagnosis word bit positions
  localparam int D_THERM = 0;
  localparam int D_WDR = 1;
  localparam int D_BUS_LO = 2;
  localparam int BUS_GROUPS = 6;

  typedef logic [WORD_W-1:0] word_t;

  typedef struct packed {
    logic osc;
    logic vcc_low;
    logic supply_uv;
    logic low_cur;
    logic sense_low;
    logic thermal;
    logic [BUS_GROUPS-1:0] bus_fail;
  } pins_t;

  typedef enum logic [5:0] {
    S_POR = 6'h01,
    S_CLOSED = 6'h02,
    S_OPEN = 6'h04,
    S_LONG = 6'h08,
    S_OFF = 6'h10,
    S_WDR = 6'h20
  } wd_state_t;

  typedef struct packed {
    pins_t s1;
    pins_t s2;
    logic cs1;
    logic cs2;
    logic cs_prev;
    logic osc_prev;
    logic [TICK_W-1:0] div;
    wd_state_t state;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] auto_cnt;
    word_t ctrl;
    word_t diag;
    logic wd_flag;
    logic rst_n;
    logic hs;
    logic ew_n;
    logic supplies_on;
  } core_t;

  localparam core_t CORE_RESET = '{state: S_POR, cs1: 1'b1, cs2: 1'b1, cs_prev: 1'b1,
                                   ew_n: 1'b1, supplies_on: 1'b1, default: '0};
endpackage

// [core/spi_link.sv]
// Purpose: serial shifter running on the host's serial clock
// Assumes: clock idles low; chip select moves only while clock is low
// Notes: chip select high clears the bit index and floats the output
`timescale 1ns/1ps
module spi_link
  import supv_pkg::*;
(
  input wire logic sclk,
  input wire logic chip_select_n,
  input wire logic serial_in,
  input wire word_t diag,
  output word_t rx_word,
  output logic serial_out,
  output logic serial_out_en
);
  logic [2:0] idx;

  // lsb first; the last eight bits of a frame are kept
  always_ff @(negedge sclk) begin
    if (!chip_select_n) begin
      rx_word <= {serial_in, rx_word[WORD_W-1:1]}; // [R2] [R1]
    end
  end

  always_ff @(negedge sclk or posedge chip_select_n) begin
    if (chip_select_n) begin
      idx <= 3'h0;
    end else begin
      idx <= idx + 3'h1;
    end
  end

  // diag is frozen by the core while a frame runs, so it is stable here
  always_ff @(posedge sclk or posedge chip_select_n) begin
    if (chip_select_n) begin
      serial_out <= 1'b0;
      serial_out_en <= 1'b0; // [R3]
    end else begin
      serial_out <= diag[idx]; // [R24] [R1]
      serial_out_en <= 1'b1;
    end
  end
endmodule // spi_link

// [core/supv_core.sv]
// Purpose: reset generator, window watchdog, high-side and mode control
// Assumes: analog comparators arrive as asynchronous level pins
// Notes: timing counts internal cycles of the divided oscillator
`timescale 1ns/1ps
// Overview of operation
// R1 - each frame swaps control and diagnosis bytes
// R2 - lsb first, input sampled on falling edge
// R3 - chip select rise loads word, floats output
// R4 - host moves chip select only with clock low
// R5 - one internal cycle is 32 oscillator periods
// R6 - reset held low 16 cycles after power good
// R7 - low regulator output drops reset at once
// R8 - watchdog begins with 16-cycle closed window
// R9 - trigger is bit 0 high then low
// R10 - missed open window pulls reset low 4 cycles
// R11 - watchdog reset sets diagnosis bit 1
// R12 - valid trigger restarts closed window immediately
// R13 - any reset clears the whole control word
// R14 - bit 1 suspends watchdog at low current
// R15 - resume gives one 32-cycle open window
// R16 - early warning output only with bit 6
// R17 - bit 5 switches high side when awake
// R18 - sleep autotiming: 2 on every 128 cycles
// R19 - diagnosis bit 0 shows thermal prewarning
// R20 - high side off in reset or lockout
// R21 - sleep cuts supplies unless bit 7 set
// R22 - bits 2,3 pick transceiver mode
// R23 - diagnosis bits 7..2 show bus failure groups
// R24 - output changes on rising clock edges
module supv_core
  import supv_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic osc_in,
  input wire logic vcc_low,
  input wire logic supply_uv,
  input wire logic low_current,
  input wire logic sense_low,
  input wire logic thermal_warn,
  input wire logic [BUS_GROUPS-1:0] bus_fail,
  input wire logic sclk,
  input wire logic chip_select_n,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_out_en,
  output logic reset_pin_n,
  output logic high_side_switch,
  output logic early_warn_n,
  output logic supplies_on,
  output logic trx_tx_enable,
  output logic trx_not_standby
);
  core_t st;
  core_t next_st;
  pins_t pins_in;
  word_t link_word;
  logic tick;
  logic load;
  logic trig;
  logic susp;
  logic sleep;

  assign pins_in = '{osc: osc_in, vcc_low: vcc_low, supply_uv: supply_uv,
                     low_cur: low_current, sense_low: sense_low,
                     thermal: thermal_warn, bus_fail: bus_fail};

  spi_link link (
    .sclk(sclk),
    .chip_select_n(chip_select_n),
    .serial_in(serial_in),
    .diag(st.diag),
    .rx_word(link_word),
    .serial_out(serial_out),
    .serial_out_en(serial_out_en)
  );

  function automatic logic at_end(input logic [CNT_W-1:0] cnt, input int len);
    return cnt == CNT_W'(len - 1);
  endfunction

  always_comb begin
    next_st = st;
    next_st.s1 = pins_in;
    next_st.s2 = st.s1;
    next_st.cs1 = chip_select_n;
    next_st.cs2 = st.cs1;
    next_st.cs_prev = st.cs2;
    next_st.osc_prev = st.s2.osc;
    tick = 1'b0;
    if (st.s2.osc && !st.osc_prev) begin
      next_st.div = st.div + TICK_W'(1);
      tick = (st.div == TICK_W'(OSC_PER_TICK - 1)); // [R5]
    end
    // frame end seen after chip select is synced high; link is idle then
    load = st.cs2 && !st.cs_prev;
    trig = load && st.ctrl[B_TRIG] && !link_word[B_TRIG]; // [R9]
    susp = st.ctrl[B_WDCTL] && st.s2.low_cur;
    sleep = !st.ctrl[B_NSTB] && st.ctrl[B_TXEN]; // [R22]
    if (load) begin
      next_st.wd_flag = 1'b0;
      if (st.rst_n) begin
        next_st.ctrl = link_word; // [R3] [R1]
      end
    end
    if (tick) begin
      next_st.cnt = st.cnt + CNT_W'(1);
      next_st.auto_cnt = st.auto_cnt + CNT_W'(1); // [R18]
    end
    unique case (st.state)
      S_POR: begin
        if (tick && at_end(st.cnt, POR_TICKS)) begin
          next_st.state = S_CLOSED; // [R6] [R8]
          next_st.cnt = '0;
          next_st.rst_n = 1'b1;
        end
      end
      S_CLOSED: begin
        if (susp) begin
          next_st.state = S_OFF; // [R14]
          next_st.cnt = '0;
        end else if (tick && at_end(st.cnt, CLOSED_TICKS)) begin
          next_st.state = S_OPEN; // [R8]
          next_st.cnt = '0;
        end
      end
      S_OPEN, S_LONG: begin
        if (susp) begin
          next_st.state = S_OFF; // [R14]
          next_st.cnt = '0;
        end else if (trig) begin
          next_st.state = S_CLOSED; // [R12]
          next_st.cnt = '0;
        end else if (tick && at_end(st.cnt, (st.state == S_LONG) ? LONG_TICKS : OPEN_TICKS)) begin
          next_st.state = S_WDR; // [R10]
          next_st.cnt = '0;
          next_st.rst_n = 1'b0;
          next_st.ctrl = '0; // [R13]
          next_st.wd_flag = 1'b1; // [R11]
        end
      end
      S_OFF: begin
        if (!susp) begin
          next_st.state = S_LONG; // [R15]
          next_st.cnt = '0;
        end
      end
      S_WDR: begin
        if (tick && at_end(st.cnt, WDR_TICKS)) begin
          next_st.state = S_CLOSED; // [R10] [R8]
          next_st.cnt = '0;
          next_st.rst_n = 1'b1;
        end
      end
    endcase
    // undervoltage overrides every watchdog phase
    if (st.s2.vcc_low) begin
      next_st.state = S_POR; // [R7]
      next_st.cnt = '0;
      next_st.rst_n = 1'b0;
      next_st.ctrl = '0; // [R13]
    end
    if (!st.rst_n || st.s2.supply_uv) begin
      next_st.hs = 1'b0; // [R20]
    end else if (sleep && st.ctrl[B_AUTO] && st.ctrl[B_HSON]) begin
      next_st.hs = st.auto_cnt < CNT_W'(AUTO_ON); // [R18]
    end else begin
      next_st.hs = st.ctrl[B_HSON]; // [R17]
    end
    next_st.ew_n = !(st.s2.sense_low && st.ctrl[B_EWEN]); // [R16]
    next_st.supplies_on = !(sleep && !st.ctrl[B_MASK]); // [R21]
    // snapshot held still while a frame is in flight
    if (st.cs2) begin
      next_st.diag = {st.s2.bus_fail, next_st.wd_flag, st.s2.thermal}; // [R23] [R19] [R11]
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      st <= CORE_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign reset_pin_n = st.rst_n;
  assign high_side_switch = st.hs;
  assign early_warn_n = st.ew_n;
  assign supplies_on = st.supplies_on;
  assign trx_tx_enable = st.ctrl[B_TXEN];
  assign trx_not_standby = st.ctrl[B_NSTB];

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);

  sequence por_done;
    st.state == S_POR && tick && at_end(st.cnt, POR_TICKS) && !st.s2.vcc_low;
  endsequence

  sequence open_expired;
    st.state == S_OPEN && tick && at_end(st.cnt, OPEN_TICKS) && !trig && !susp && !st.s2.vcc_low;
  endsequence

  sequence wdr_done;
    st.state == S_WDR && tick && at_end(st.cnt, WDR_TICKS) && !st.s2.vcc_low;
  endsequence

  a_por_release: assert property (por_done |=> reset_pin_n && st.state == S_CLOSED && st.cnt == '0) // [R6]
    else $error("reset not released after power-on delay");
  a_por_hold: assert property (st.state == S_POR |-> !reset_pin_n) // [R6]
    else $error("reset high during power-on delay");
  a_uv_reset: assert property (st.s2.vcc_low |=> !reset_pin_n && st.state == S_POR) // [R7]
    else $error("undervoltage did not drop reset");
  a_ctrl_clear: assert property (!reset_pin_n |-> st.ctrl == 8'h00) // [R13]
    else $error("control word not cleared in reset");
  a_wd_timeout: assert property (open_expired |=> !reset_pin_n && st.wd_flag && st.state == S_WDR) // [R10]
    else $error("missed open window did not reset");
  a_wd_pulse_end: assert property (wdr_done |=> reset_pin_n && st.state == S_CLOSED) // [R10]
    else $error("watchdog reset pulse length wrong");
  // a frame ending right after the timeout clears the flag, so skip that case
  a_diag_wd_bit: assert property (open_expired ##1 (st.cs2 && !load) |=> st.diag[D_WDR]) // [R11]
    else $error("watchdog reset not shown in diagnosis");
  a_trig_restart: assert property ((st.state inside {S_OPEN, S_LONG}) && trig && !susp && !st.s2.vcc_low
      |=> st.state == S_CLOSED && st.cnt == '0) // [R12]
    else $error("valid trigger did not restart window");
  a_wd_suspend: assert property ((st.state inside {S_CLOSED, S_OPEN, S_LONG}) && susp && !st.s2.vcc_low
      |=> st.state == S_OFF) // [R14]
    else $error("watchdog not suspended at low current");
  a_resume_long: assert property (st.state == S_OFF && !susp && !st.s2.vcc_low
      |=> st.state == S_LONG && st.cnt == '0) // [R15]
    else $error("resume did not open long window");
  a_hs_forced_off: assert property (!reset_pin_n || st.s2.supply_uv |=> !high_side_switch) // [R20]
    else $error("high side on during reset or lockout");
  a_ew_gate: assert property (!st.ctrl[B_EWEN] |=> early_warn_n) // [R16]
    else $error("early warning low while disabled");
  a_supply_cut: assert property (sleep && !st.ctrl[B_MASK] |=> !supplies_on) // [R21]
    else $error("supplies stay on in unmasked sleep");
endmodule // supv_core

// [sim/spi_host_model.sv]
// Purpose: host side of the serial link, 6 ns serial clock
// Assumes: clock stands low outside frames
// Notes: a bit seen while the output is floating reads as x
`timescale 1ns/1ps
module spi_host_model
  import supv_pkg::*;
(
  output logic sclk,
  output logic chip_select_n,
  output logic serial_in,
  input wire logic serial_out,
  input wire logic serial_out_en
);
  initial begin
    sclk = 1'b0;
    chip_select_n = 1'b1;
    serial_in = 1'b0;
  end
  task automatic xfer(input word_t tx, output word_t rx);
    chip_select_n = 1'b0;
    for (int i = 0; i < WORD_W; i++) begin
      #1 serial_in = tx[i];
      #2 sclk = 1'b1;
      #3 rx[i] = serial_out_en ? serial_out : 1'bx;
      sclk = 1'b0;
    end
    #3 chip_select_n = 1'b1;
    serial_in = 1'b0;
  endtask
endmodule // spi_host_model

// [sim/supv_core_bench.sv]
// Purpose: self-checking bench of the supervisor
// Assumes: osc at mclk/4, so one tick is 128 mclk
// Notes: windows are judged with one or two ticks of slack for tick phase
`timescale 1ns/1ps
module supv_core_bench
  import supv_pkg::*;
;
  localparam int TK = 128;
  logic mclk = 0, srst = 1, vcc_low = 0, supply_uv = 0, low_current = 0;
  logic sense_low = 0, thermal_warn = 0;
  logic [BUS_GROUPS-1:0] bus_fail = '0;
  logic [1:0] od = '0;
  wire osc_in = od[1];
  logic sclk, chip_select_n, serial_in, serial_out, serial_out_en, reset_pin_n;
  logic high_side_switch, early_warn_n, supplies_on, trx_tx_enable, trx_not_standby;
  int fails = 0, checked = 0;
  word_t rx, w;
  always #12.5 mclk = ~mclk;
  always @(posedge mclk) od <= od + 2'h1;
  supv_core supv_core_inst (.mclk, .srst, .osc_in, .vcc_low, .supply_uv, .low_current, .sense_low,
    .thermal_warn, .bus_fail, .sclk, .chip_select_n, .serial_in, .serial_out, .serial_out_en,
    .reset_pin_n, .high_side_switch, .early_warn_n, .supplies_on, .trx_tx_enable, .trx_not_standby);
  spi_host_model spi_host_model_inst (.sclk, .chip_select_n, .serial_in, .serial_out, .serial_out_en);
  task automatic chk(string s, logic [7:0] got, logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", s, exp, got);
    end
  endtask
  function automatic logic pick(int sel);
    return sel ? high_side_switch : reset_pin_n;
  endfunction
  // bounded wait for a level; elapsed time must land in [lo,hi] ticks
  task automatic win(string s, int sel, logic lvl, int lo, int hi);
    int c;
    c = 0;
    while (pick(sel) !== lvl && c <= hi * TK) begin
      @(negedge mclk);
      c++;
    end
    chk(s, 8'(c >= lo * TK && c <= hi * TK), 8'h01);
  endtask
  // synced inputs settle first, control word lands after
  task automatic fr(word_t tx);
    repeat (8) @(negedge mclk);
    spi_host_model_inst.xfer(tx, rx);
    repeat (6) @(negedge mclk);
  endtask
  task automatic wt(int n);
    repeat (n * TK) @(negedge mclk);
  endtask
  task automatic end_sim;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge mclk);
    fails++;
    end_sim;
  end
  initial begin
    void'($urandom(32'hfda5));
    repeat (5) @(posedge mclk);
    srst <= 1'b0;
    @(negedge mclk);
    chk("por_out", 8'({reset_pin_n, early_warn_n, supplies_on, high_side_switch}), 8'h06);
    win("por", 0, 1'b1, 15, 18);
    for (int k = 0; k < 3; k++) begin
      @(posedge mclk);
      w = 8'($urandom);
      w[3:0] = 4'hd;
      bus_fail <= 6'($urandom);
      thermal_warn <= 1'($urandom);
      sense_low <= 1'($urandom);
      fr(w);
      chk("diag", rx, {bus_fail, 1'b0, thermal_warn});
      chk("so_en", 8'(serial_out_en), 8'h00);
      chk("ctl", 8'({trx_not_standby, trx_tx_enable, high_side_switch}), 8'({w[3:2], w[5]}));
      chk("ew", 8'(early_warn_n), 8'(!(sense_low & w[6])));
      wt(20);
      fr(w & 8'hfe);
    end
    chk("alive", 8'(reset_pin_n), 8'h01);
    fr(8'h01);
    wt(5);
    // too early: must not restart the window
    fr(8'h00);
    win("wdto", 0, 1'b0, 24, 28);
    repeat (2) @(negedge mclk);
    chk("clr", 8'({trx_not_standby, trx_tx_enable, high_side_switch}), 8'h00);
    win("wdr", 0, 1'b1, 3, 5);
    @(posedge mclk);
    low_current <= 1'b1;
    fr(8'h03);
    chk("wdflag", 8'(rx[1]), 8'h01);
    wt(40);
    chk("susp", 8'(reset_pin_n), 8'h01);
    @(posedge mclk);
    low_current <= 1'b0;
    wt(5);
    // accepted only if the first window after resume is open
    fr(8'h02);
    win("long", 0, 1'b0, 30, 34);
    win("wdr2", 0, 1'b1, 3, 5);
    fr(8'h2c);
    chk("hs_on", 8'(high_side_switch), 8'h01);
    @(posedge mclk);
    supply_uv <= 1'b1;
    repeat (6) @(negedge mclk);
    chk("uv", 8'(high_side_switch), 8'h00);
    @(posedge mclk);
    supply_uv <= 1'b0;
    vcc_low <= 1'b1;
    repeat (6) @(negedge mclk);
    chk("uvrst", 8'({reset_pin_n, trx_not_standby, trx_tx_enable}), 8'h00);
    @(posedge mclk);
    vcc_low <= 1'b0;
    win("por2", 0, 1'b1, 15, 18);
    @(posedge mclk);
    low_current <= 1'b1;
    fr(8'h36);
    chk("sup_off", 8'(supplies_on), 8'h00);
    // start from a low phase so the on-time is measured from its start
    win("auto_off", 1, 1'b0, 0, 3);
    win("auto_on", 1, 1'b1, 0, 129);
    win("auto_len", 1, 1'b0, 1, 3);
    win("auto_per", 1, 1'b1, 125, 127);
    fr(8'hb6);
    chk("sup_mask", 8'(supplies_on), 8'h01);
    end_sim;
  end
endmodule // supv_core_bench
